// File: design/eoc_pulse_gen.sv
`default_nettype none
module eoc_pulse_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pulse request and state
  eoc_pulse_if.gen pulse
);
  import hall_seq_pkg::*;

  typedef struct packed {
    logic active;
    logic [EOC_CNT_W-1:0] cnt;
  } gen_state_t;

  gen_state_t r;
  gen_state_t n;

  ////////////////////////////////////////////////////////////////////////////
  // A request during a running pulse is merged into it, so the low time is
  // always exact and a fast run of completions cannot hold the line low.
  always_comb begin
    n = r;
    if (pulse.start && !r.active) begin
      n.active = 1'b1;
      n.cnt = EOC_LOAD;
    end else if (r.active) begin
      if (r.cnt == '0) begin
        n.active = 1'b0;
      end else begin
        n.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pulse.active = r.active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. The low time is counted apart from the down-counter, so a wrong
  // load value or a wrong end test shows up here.
  logic [EOC_CNT_W:0] low_len;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_len <= '0;
    end else if (r.active) begin
      low_len <= low_len + 1'b1;
    end else begin
      low_len <= '0;
    end
  end

  property p_eoc_width;
    @(posedge mclk) disable iff (rst) $fell(r.active) |-> low_len == EOC_LOW_CYCLES;
  endproperty
  a_eoc_width: assert property (p_eoc_width) else $error("completion pulse width wrong");

endmodule
`default_nettype wire

// File: design/eoc_pulse_if.sv
`default_nettype none
interface eoc_pulse_if;
  logic start;
  logic active;
  modport ctrl (output start, input active);
  modport gen (input start, output active);
endinterface
`default_nettype wire

// File: design/hall_measurement_cycle_sequencer.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module hall_measurement_cycle_sequencer #(
  parameter int unsigned LP_SLOW_PERIOD = hall_seq_pkg::LP_SLOW_CYCLES,
  parameter int unsigned LP_FAST_PERIOD = hall_seq_pkg::LP_FAST_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [hall_seq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hall_seq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter front end
  output logic conv_start,
  output logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [hall_seq_pkg::RES_W-1:0] conv_data,
  // External trigger pin
  input wire logic ext_trig,
  // Completion line and interrupt
  output logic eoc_n,
  output logic irq
);
  import hall_seq_pkg::*;

  typedef enum logic {ST_IDLE, ST_CONV} seq_st_t;

  typedef struct packed {
    logic aw_got;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [3:0][RES_W-1:0] res;
    seq_st_t st;
    chan_t chan;
    chan_cfg_t cyc_cfg;
    logic conv_start;
    logic pend;
    logic [LP_CNT_W-1:0] lp_cnt;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
  } state_t;

  localparam state_t STATE_RESET = '{ctrl: CTRL_RESET, mask: MASK_RESET, st: ST_IDLE,
                                     chan: CH_X, cyc_cfg: CFG_XYZT, default: '0};

  state_t r;
  state_t n;
  mode_t seq_mode;
  chan_cfg_t sel_cfg;
  logic [LP_CNT_W-1:0] lp_last;
  logic lp_tick;
  logic ext_edge;
  logic sw_trig;
  logic trig_any;
  logic go;
  logic wr_en;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;

  eoc_pulse_if eoc_if ();

  eoc_pulse_gen u_eoc (
    .mclk(mclk),
    .rst(rst),
    .pulse(eoc_if.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.conv_start = 1'b0;
    eoc_if.start = 1'b0;
    st_set = '0;
    seq_mode = mode_t'(r.ctrl[CTRL_MODE_LSB +: 2]);
    sel_cfg = chan_cfg_t'(r.ctrl[CTRL_CFG_LSB +: 2]);

    // The pin is asynchronous; the edge detector compares the second and third stages.
    n.trig_s1 = ext_trig;
    n.trig_s2 = r.trig_s1;
    n.trig_s3 = r.trig_s2;
    ext_edge = r.trig_s2 & ~r.trig_s3;

    // Register writes: address and data may arrive in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    wr_en = r.aw_got && r.w_got && r.wstrb[0];
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_en && r.awaddr == ADDR_CTRL) begin
      n.ctrl = r.wdata[CTRL_W-1:0];
    end
    if (wr_en && r.awaddr == ADDR_MASK) begin
      n.mask = r.wdata[ST_W-1:0];
    end
    st_clr = (wr_en && r.awaddr == ADDR_STATUS) ? r.wdata[ST_W-1:0] : '0;
    sw_trig = wr_en && r.awaddr == ADDR_TRIG && r.wdata[TRIG_BIT];

    // Register reads; unmapped addresses read as zero.
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      case (s_axi_araddr)
        ADDR_CTRL: n.rdata = {{(32 - CTRL_W){1'b0}}, r.ctrl};
        ADDR_STATUS: n.rdata = {29'h0, r.st == ST_CONV, r.status};
        ADDR_MASK: n.rdata = {30'h0, r.mask};
        ADDR_RES_X: n.rdata = {20'h0, r.res[CH_X]};
        ADDR_RES_Y: n.rdata = {20'h0, r.res[CH_Y]};
        ADDR_RES_Z: n.rdata = {20'h0, r.res[CH_Z]};
        ADDR_RES_T: n.rdata = {20'h0, r.res[CH_T]};
        default: n.rdata = 32'h0000_0000;
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    lp_last = r.ctrl[CTRL_RATE_BIT] ? LP_CNT_W'(LP_FAST_PERIOD - 1)
                                    : LP_CNT_W'(LP_SLOW_PERIOD - 1);
    lp_tick = 1'b0;
    if (seq_mode != MODE_LOW_POWER) begin
      n.lp_cnt = '0;
    end else if (r.lp_cnt >= lp_last) begin
      n.lp_cnt = '0;
      lp_tick = 1'b1;
    end else begin
      n.lp_cnt = r.lp_cnt + 1'b1;
    end

    trig_any = (seq_mode == MODE_LOW_POWER && (lp_tick || ext_edge)) ||
               (seq_mode == MODE_MASTER && (sw_trig || ext_edge));
    // A trigger during a running cycle is held and starts the next one.
    if (seq_mode == MODE_FAST || seq_mode == MODE_POWER_DOWN) begin
      n.pend = 1'b0;
    end else if (trig_any) begin
      n.pend = 1'b1;
    end
    go = seq_mode == MODE_FAST || r.pend || trig_any;

    case (r.st)
      ST_IDLE: begin
        if (go) begin
          n.st = ST_CONV;
          n.chan = CH_X;
          n.cyc_cfg = sel_cfg;
          n.conv_start = 1'b1;
          n.pend = 1'b0;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          n.res[r.chan] = conv_data;
          st_set[ST_CONV_BIT] = 1'b1;
          eoc_if.start = r.ctrl[CTRL_EOC_EN_BIT];
          if (r.chan == last_chan(r.cyc_cfg)) begin
            st_set[ST_CYCLE_BIT] = 1'b1;
            if (seq_mode == MODE_FAST) begin
              n.chan = CH_X;
              n.cyc_cfg = sel_cfg;
              n.conv_start = 1'b1;
            end else begin
              n.st = ST_IDLE;
            end
          end else begin
            n.chan = chan_t'(r.chan + 2'h1);
            n.conv_start = 1'b1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // A new event wins over a clear written in the same cycle.
    n.status = (r.status & ~st_clr) | st_set;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= STATE_RESET;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = RESP_OKAY;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = RESP_OKAY;
  assign conv_start = r.conv_start;
  assign conv_chan = r.chan;
  assign eoc_n = !eoc_if.active;
  assign irq = |(r.status & r.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_fast_restart;
    (r.st == ST_CONV && conv_done && r.chan == last_chan(r.cyc_cfg) && seq_mode == MODE_FAST)
      |=> (conv_start && conv_chan == CH_X);
  endproperty
  a_fast_restart: assert property (p_fast_restart) else $error("fast mode did not restart");
  property p_no_untriggered;
    (r.st == ST_IDLE && seq_mode != MODE_FAST && !r.pend && !trig_any) |=> !conv_start;
  endproperty
  a_no_untriggered: assert property (p_no_untriggered) else $error("cycle without trigger");
  property p_temp_ends;
    (r.st == ST_CONV && conv_done && r.cyc_cfg == CFG_XYZT && r.chan == CH_T && seq_mode != MODE_FAST)
      |=> (r.st == ST_IDLE && r.status[ST_CYCLE_BIT]);
  endproperty
  a_temp_ends: assert property (p_temp_ends) else $error("temperature did not end cycle");
  property p_xyz_no_temp;
    (conv_start && r.cyc_cfg == CFG_XYZ) |-> conv_chan != CH_T;
  endproperty
  a_xyz_no_temp: assert property (p_xyz_no_temp) else $error("temperature in three-axis set");
  property p_xy_only;
    (conv_start && r.cyc_cfg == CFG_XY) |-> (conv_chan == CH_X || conv_chan == CH_Y);
  endproperty
  a_xy_only: assert property (p_xy_only) else $error("extra channel in two-axis set");
  property p_order;
    (conv_start && conv_chan != CH_X) |-> $past(conv_chan) == conv_chan - 2'h1;
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
  property p_eoc_start;
    (r.st == ST_CONV && conv_done && r.ctrl[CTRL_EOC_EN_BIT] && eoc_n) |=> !eoc_n;
  endproperty
  a_eoc_start: assert property (p_eoc_start) else $error("completion pulse missing");
  property p_lp_tick;
    (seq_mode == MODE_LOW_POWER && r.st == ST_IDLE && lp_tick) |=> conv_start;
  endproperty
  a_lp_tick: assert property (p_lp_tick) else $error("periodic trigger ignored");
  property p_master_cmd;
    (seq_mode == MODE_MASTER && r.st == ST_IDLE && sw_trig) |=> conv_start;
  endproperty
  a_master_cmd: assert property (p_master_cmd) else $error("bus command ignored");

endmodule
`default_nettype wire

// File: design/hall_seq_pkg.sv
`default_nettype none
package hall_seq_pkg;

  // Clock.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_HZ = 250_000_000;

  // Completion pulse: 1.8 us least, 3.2 us longest; the block uses the least, rounded up.
  localparam int unsigned EOC_LOW_MIN_NS = 1800;
  localparam int unsigned EOC_LOW_MAX_NS = 3200;
  localparam int unsigned EOC_LOW_CYCLES = (EOC_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EOC_LOW_MAX_CYCLES = EOC_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int EOC_CNT_W = 10;
  localparam logic [EOC_CNT_W-1:0] EOC_LOAD = EOC_CNT_W'(EOC_LOW_CYCLES - 1);

  // Low-power update rates.
  localparam int unsigned LP_SLOW_HZ = 10;
  localparam int unsigned LP_FAST_HZ = 160;
  localparam int unsigned LP_SLOW_CYCLES = CLK_HZ / LP_SLOW_HZ;
  localparam int unsigned LP_FAST_CYCLES = CLK_HZ / LP_FAST_HZ;
  localparam int LP_CNT_W = 25;

  // Register map.
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] ADDR_TRIG = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] ADDR_MASK = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RES_X = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RES_Y = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RES_Z = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RES_T = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  localparam int CTRL_W = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CFG_LSB = 2;
  localparam int CTRL_EOC_EN_BIT = 4;
  localparam int CTRL_RATE_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h10;
  localparam int TRIG_BIT = 0;
  localparam int ST_W = 2;
  localparam int ST_CONV_BIT = 0;
  localparam int ST_CYCLE_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam logic [ST_W-1:0] MASK_RESET = 2'h0;
  localparam int RES_W = 12;

  typedef enum logic [1:0] {MODE_POWER_DOWN, MODE_LOW_POWER, MODE_FAST, MODE_MASTER} mode_t;
  typedef enum logic [1:0] {CFG_XYZT, CFG_XYZ, CFG_XY, CFG_SPARE} chan_cfg_t;
  typedef enum logic [1:0] {CH_X, CH_Y, CH_Z, CH_T} chan_t;

  // Channel that closes a cycle; the spare code behaves as the full set.
  function automatic chan_t last_chan(input chan_cfg_t cfg);
    case (cfg)
      CFG_XYZ: last_chan = CH_Z;
      CFG_XY: last_chan = CH_Y;
      default: last_chan = CH_T;
    endcase
  endfunction

endpackage
`default_nettype wire

// File: sim/conv_front_model.sv
`default_nettype none
module conv_front_model (
  // Clock
  input wire logic mclk,
  // Request from the sequencer, and the speed select from the testbench
  input wire logic conv_start,
  input wire logic slow,
  // Answer to the sequencer
  output logic conv_done,
  output logic [hall_seq_pkg::RES_W-1:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    conv_done = 1'b0;
    conv_data = 12'hA5C;
  end

  // Outside a done pulse the data lines show the inverse, so a stale sample never matches.
  always @(posedge mclk) begin
    if (conv_start === 1'b1) begin
      repeat (slow ? 40 : 3) @(posedge mclk);
      conv_done <= 1'b1;
      conv_data <= 12'($urandom);
      @(posedge mclk);
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
  end
endmodule
`default_nettype wire

// File: sim/hall_measurement_cycle_sequencer_tb_top.sv
`default_nettype none
module hall_measurement_cycle_sequencer_tb_top import hall_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, awv, wv, bready, arv, rready, ext_trig, slow;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, eoc_n, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, conv_chan;
  logic [11:0] conv_data;
  logic [1:0] chq[$];
  logic [11:0] dq[$];
  logic [31:0] exp_res[4];
  int stq[$], dnq[$], wq[$];
  int mismatches = 0, checked = 0, cyc = 0, lowcnt = 0;
  // Aim the first result read well inside the window after the completion line rises.
  localparam int RD1_WAIT = 35_000 / CLK_PERIOD_NS;

  hall_measurement_cycle_sequencer #(.LP_SLOW_PERIOD(200), .LP_FAST_PERIOD(50)) dut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_data(conv_data), .ext_trig(ext_trig), .eoc_n(eoc_n), .irq(irq));
  conv_front_model partner (.mclk(mclk), .conv_start(conv_start), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) begin
      chq.push_back(conv_chan);
      stq.push_back(cyc);
    end
    if (conv_done === 1'b1) begin
      dq.push_back(conv_data);
      dnq.push_back(cyc);
    end
    if (eoc_n === 1'b0) lowcnt <= lowcnt + 1;
    else if (lowcnt != 0) begin
      wq.push_back(lowcnt);
      lowcnt <= 0;
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Each channel is released at its own handshake; a stuck slave ends in the bound.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge mclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    check_val(32'(bresp), 32'(RESP_OKAY), "write response");
    if (n == 1000) mismatches++;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge mclk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rready <= 1'b0;
    check_val(32'(rresp), 32'(RESP_OKAY), "read response");
    if (n == 1000) mismatches++;
  endtask

  task automatic wait_done(input int want);
    int n;
    for (n = 0; n < 3000 && dq.size() < want; n++) @(posedge mclk);
    if (n == 3000) mismatches++;
  endtask

  task automatic clr();
    @(negedge mclk);
    chq.delete();
    dq.delete();
    stq.delete();
    dnq.delete();
    wq.delete();
  endtask

  task automatic pulse_ext();
    @(posedge mclk);
    ext_trig <= 1'b1;
    repeat (4) @(posedge mclk);
    ext_trig <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18251));
    {rst, awv, wv, bready, arv, rready, ext_trig, slow} = 8'h80;
    {awaddr, araddr, wdata, wstrb} = '0;
    exp_res = '{default: 32'h0};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(ADDR_CTRL, rd);
    check_val(rd, 32'(CTRL_RESET), "ctrl reset");
    check_val({31'h0, eoc_n}, 32'h1, "eoc idle");
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      int n;
      n = (c == 1) ? 3 : (c == 2) ? 2 : 4;
      slow <= 1'($urandom);
      clr();
      wr(ADDR_CTRL, 32'(3 | (c << 2) | 16));
      repeat (30) @(posedge mclk);
      check_val(chq.size(), 0, "start without trigger");
      if (c == 2) pulse_ext();
      else wr(ADDR_TRIG, 32'h1);
      wait_done(n);
      repeat (30) @(posedge mclk);
      check_val(chq.size(), n, "channels in cycle");
      for (int k = 0; k < n; k++) begin
        check_val(32'(chq[k]), k, "conversion order");
        exp_res[k] = 32'(dq[k]);
      end
      for (int w = 0; w < 1000 && eoc_n !== 1'b1; w++) @(posedge mclk);
      repeat (RD1_WAIT) @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
        rd_reg(ADDR_RES_X + 8'(4 * k), rd);
        check_val(rd, exp_res[k], "result");
      end
      $display("test master cycle %0d done", c);
    end
    repeat (500) @(posedge mclk);
    check_val(wq.size() > 0, 1, "completion pulse seen");
    foreach (wq[i]) check_val(wq[i], EOC_LOW_CYCLES, "completion pulse width");
    check_val({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_MASK, 32'h1);
    check_val({31'h0, irq}, 32'h1, "irq conv");
    wr(ADDR_STATUS, 32'h1);
    rd_reg(ADDR_STATUS, rd);
    check_val(rd, 32'h2, "status after clear");
    check_val({31'h0, irq}, 32'h0, "irq cleared");
    wr(ADDR_MASK, 32'h2);
    check_val({31'h0, irq}, 32'h1, "irq cycle");
    wr(ADDR_STATUS, 32'h2);
    check_val({31'h0, irq}, 32'h0, "irq cleared");
    wr(8'h40, 32'hFFFF_FFFF);
    rd_reg(8'h40, rd);
    check_val(rd, 32'h0, "unmapped");
    $display("test irq done");
    // The pulse enable is off here, so no completion pulse may appear.
    slow <= 1'b0;
    clr();
    wr(ADDR_CTRL, 32'h06);
    wait_done(3);
    rd_reg(ADDR_RES_Z, rd);
    check_val(rd, 32'(dq[2]), "fast in-step read");
    wait_done(7);
    wr(ADDR_CTRL, 32'h00);
    repeat (200) @(posedge mclk);
    for (int k = 0; k < 7; k++) check_val(32'(chq[k]), k % 3, "fast order");
    check_val(stq[3] - dnq[2], 1, "fast restart");
    check_val(stq[6] - dnq[5], 1, "fast restart");
    check_val(wq.size(), 0, "pulse disabled");
    $display("test fast done");
    for (int r = 0; r < 2; r++) begin
      clr();
      wr(ADDR_CTRL, 32'(1 | (2 << 2) | (r << 5)));
      wait_done(6);
      wr(ADDR_CTRL, 32'h00);
      repeat (100) @(posedge mclk);
      check_val(stq[2] - stq[0], r ? 50 : 200, "low power period");
      check_val(stq[4] - stq[2], r ? 50 : 200, "low power period");
      check_val(32'(chq[3]), 1, "low power order");
      $display("test low power %0d done", r);
    end
    clr();
    pulse_ext();
    repeat (100) @(posedge mclk);
    check_val(chq.size(), 0, "power down");
    $display("test power down done");
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
